// File: core/rtc_ctrl_status.v
// Purpose: control and status registers of a real-time clock
// Assumes: time counters and alarm compare live outside
// Notes:   carry inputs show the counter value before increment
`include "rtc_consts.vh"

module rtc_ctrl_status (
  input  wire       mclk,         // 25 MHz system clock
  input  wire       srst,         // sync reset, high
  input  wire       ce_pin,       // link chip enable
  input  wire       sclk_pin,     // link clock
  input  wire       sio_in,       // link data in
  output wire       sio_out,      // link data out
  output wire       sio_oe_n,     // link data enable, low drives
  input  wire       osc_pin,      // 32.768 kHz oscillator
  input  wire       pwr_zero_pin, // supply rose from zero volts
  input  wire       vlow21_pin,   // supply below 2.1 V
  input  wire       vlow135_pin,  // supply below 1.35 V
  input  wire       osc_halt_pin, // oscillator halt sensed
  input  wire       alarm_w_match,// weekly alarm time match pulse
  input  wire       alarm_d_match,// daily alarm time match pulse
  input  wire       sec_carry,    // seconds at 59
  input  wire       min_carry,    // minutes at 59
  input  wire       hour_carry,   // last hour of day
  input  wire       month_carry,  // last day of month
  input  wire [4:0] hour_bin,     // hour counter, 0 to 23
  output reg  [5:0] hour_code,    // hour as read by host
  output wire       ext_wr_stb,   // write to outside registers
  output wire [3:0] ext_addr,     // outside register address
  output wire [7:0] ext_wdata,    // outside write data
  input  wire [7:0] ext_rdata,    // outside read data
  output reg        sec_inc,      // second counter increment
  output wire       irq_out,      // irq pin output level
  output reg        irq_oe_n,     // irq pin enable, low drives
  output wire       hour_24,      // hour format
  output wire       test_mode,    // factory test mode
  output wire       supply_threshold_sel, // monitor threshold
  output wire       mon_en,       // supply monitor running
  output wire [7:0] adj_out       // correction setting
);
  localparam integer SECINC_CYC = (`T_SECINC_NS * `MCLK_MHZ) / 1000;
  localparam integer ALARM_CYC  = (`T_ALARM_NS * `MCLK_MHZ) / 1000;

  reg [7:0] cr1_r, adj_r;
  reg       thresh_r, lowsup_r, oscrun_r, pwrup_r, spa_r;
  reg       lvl_r, wk_flg_r, dy_flg_r;
  reg [2:0] pz_s, v21_s, v135_s, oh_s;
  reg [11:0] dly_r;
  reg [9:0] aw_cnt, ad_cnt;
  reg [7:0] rdata;

  wire       wr_stb, rd_req;
  wire [3:0] addr;
  wire [7:0] wdata;
  wire [`DIV_W-1:0] div;
  wire       tick;

  // bcd of 0..23
  function [5:0] bcd;
    input [4:0] n;
    begin
      if (n >= 5'd20)
        bcd = {1'b0, n} + 6'd12;
      else if (n >= 5'd10)
        bcd = {1'b0, n} + 6'd6;
      else
        bcd = {1'b0, n};
    end
  endfunction

  sio_link u_link (
    .mclk     (mclk),
    .srst     (srst),
    .ce_pin   (ce_pin),
    .sclk_pin (sclk_pin),
    .sio_in   (sio_in),
    .sio_out  (sio_out),
    .sio_oe_n (sio_oe_n),
    .wr_stb   (wr_stb),
    .addr_r   (addr),
    .wdata    (wdata),
    .rd_req   (rd_req),
    .rdata    (rdata)
  );

  wire wr_adj = wr_stb & (addr == `A_ADJ);
  wire wr_cr1 = wr_stb & (addr == `A_CR1);
  wire wr_cr2 = wr_stb & (addr == `A_CR2);
  wire wr_sec = wr_stb & (addr == `A_SEC);
  wire ours   = (addr == `A_ADJ) | (addr == `A_CR1) | (addr == `A_CR2);

  sec_timebase u_tb (
    .mclk    (mclk),
    .srst    (srst),
    .osc_pin (osc_pin),
    .clr     (wr_sec),
    .adj     (adj_r),
    .div_r   (div),
    .tick    (tick)
  );

  assign ext_wr_stb = wr_stb & ~ours;
  assign ext_addr   = addr;
  assign ext_wdata  = wdata;
  assign hour_24    = cr1_r[`B_H24];
  assign test_mode  = cr1_r[`B_TEST];
  assign supply_threshold_sel = thresh_r;
  assign mon_en     = ~lowsup_r;
  assign adj_out    = adj_r;
  assign irq_out    = 1'b0;

  // status pins cross two flops before use
  always @(posedge mclk) begin
    pz_s   <= {pz_s[1:0], pwr_zero_pin};
    v21_s  <= {v21_s[1:0], vlow21_pin};
    v135_s <= {v135_s[1:0], vlow135_pin};
    oh_s   <= {oh_s[1:0], osc_halt_pin};
  end

  // periodic select decode
  wire [2:0] psel  = cr1_r[2:0];
  wire pulse_mode  = (psel == `PS_P2) | (psel == `PS_P1);
  wire level_mode  = psel[2];
  // pulse wave is low in the first half of each period
  wire pulse_low   = (psel == `PS_P1) ? ~div[`DIV_W-1] :
                     (psel == `PS_P2) ? ~div[`DIV_W-2] : 1'b0;
  reg  lvl_hit;
  always @* begin
    case (psel)
      `PS_L1S:  lvl_hit = 1'b1;
      `PS_L1M:  lvl_hit = sec_carry;
      `PS_L1H:  lvl_hit = sec_carry & min_carry;
      `PS_L1MO: lvl_hit = sec_carry & min_carry & hour_carry &
                          month_carry;
      default:  lvl_hit = 1'b0;
    endcase
  end
  wire per_low = (psel == `PS_LOW) | pulse_low | lvl_r;
  wire irq_drv = per_low | wk_flg_r | dy_flg_r;

  // hour code for host reads
  always @(posedge mclk) begin
    if (srst)
      hour_code <= 6'h00;
    else if (cr1_r[`B_H24])
      hour_code <= bcd(hour_bin);
    else if (hour_bin == 5'd0)
      hour_code <= 6'h12;
    else if (hour_bin < 5'd12)
      hour_code <= bcd(hour_bin);
    else if (hour_bin == 5'd12)
      hour_code <= 6'h32;
    else
      hour_code <= bcd(hour_bin - 5'd12) + 6'h20;
  end

  // power-up flag; set wins over clear
  always @(posedge mclk) begin
    if (srst | pz_s[1])
      pwrup_r <= 1'b1;
    else if (wr_cr2 & ~wdata[`B_PWRUP])
      pwrup_r <= 1'b0;
  end

  // oscillator flag; halt wins over any write
  always @(posedge mclk) begin
    if (srst | oh_s[1])
      oscrun_r <= 1'b0;
    else if (wr_cr2)
      oscrun_r <= wdata[`B_OSCRUN];
  end

  // control bits, held clear while the power-up flag stands
  always @(posedge mclk) begin
    if (srst | pwrup_r) begin
      cr1_r    <= 8'h00;
      adj_r    <= 8'h00;
      thresh_r <= 1'b0;
      spa_r    <= 1'b0;
    end else begin
      if (wr_cr1)
        cr1_r <= wdata;
      if (wr_adj)
        adj_r <= wdata;
      if (wr_cr2) begin
        thresh_r <= wdata[`B_THRESH];
        spa_r  <= wdata[`B_SPA];
      end
    end
  end

  // supply monitor halts once low is seen
  wire vlow = thresh_r ? v135_s[1] : v21_s[1];
  always @(posedge mclk) begin
    if (srst | pwrup_r)
      lowsup_r <= 1'b0;
    else if (~lowsup_r & vlow)
      lowsup_r <= 1'b1;
    else if (wr_cr2 & ~wdata[`B_LOWSUP] & ~vlow)
      lowsup_r <= 1'b0;
  end

  // level interrupt latch; a hit wins over a clear
  always @(posedge mclk) begin
    if (srst | pwrup_r | ~level_mode)
      lvl_r <= 1'b0;
    else if (tick & lvl_hit)
      lvl_r <= 1'b1;
    else if (wr_cr2 & ~wdata[`B_PERFLG])
      lvl_r <= 1'b0;
  end

  // second increment: delayed in pulse mode, else on the tick
  always @(posedge mclk) begin
    sec_inc <= 1'b0;
    if (srst) begin
      dly_r <= 12'h000;
    end else if (pulse_mode) begin
      if (tick)
        dly_r <= SECINC_CYC[11:0];
      else if (dly_r != 12'h000) begin
        dly_r <= dly_r - 12'h001;
        if (dly_r == 12'h001)
          sec_inc <= 1'b1;
      end
    end else begin
      dly_r   <= 12'h000;
      sec_inc <= tick;
    end
  end

  // alarm delay counters and flags
  always @(posedge mclk) begin
    if (srst | pwrup_r) begin
      aw_cnt   <= 10'h000;
      ad_cnt   <= 10'h000;
      wk_flg_r <= 1'b0;
      dy_flg_r <= 1'b0;
    end else begin
      if (alarm_w_match)
        aw_cnt <= ALARM_CYC[9:0];
      else if (aw_cnt != 10'h000)
        aw_cnt <= aw_cnt - 10'h001;
      if (alarm_d_match)
        ad_cnt <= ALARM_CYC[9:0];
      else if (ad_cnt != 10'h000)
        ad_cnt <= ad_cnt - 10'h001;
      if (~cr1_r[`B_WK_EN])
        wk_flg_r <= 1'b0;
      else if (aw_cnt == 10'h001)
        wk_flg_r <= 1'b1;
      else if (wr_cr2 & ~wdata[`B_WKFLG])
        wk_flg_r <= 1'b0;
      if (~cr1_r[`B_DY_EN])
        dy_flg_r <= 1'b0;
      else if (ad_cnt == 10'h001)
        dy_flg_r <= 1'b1;
      else if (wr_cr2 & ~wdata[`B_DYFLG])
        dy_flg_r <= 1'b0;
    end
  end

  // open-drain irq pin, registered enable
  always @(posedge mclk) begin
    if (srst)
      irq_oe_n <= 1'b1;
    else
      irq_oe_n <= ~irq_drv;
  end

  // read data mux for the link
  always @* begin
    case (addr)
      `A_ADJ:  rdata = adj_r;
      `A_CR1:  rdata = cr1_r;
      `A_CR2:  rdata = {thresh_r, lowsup_r, oscrun_r, pwrup_r, spa_r,
                        per_low, wk_flg_r, dy_flg_r};
      default: rdata = ext_rdata;
    endcase
  end
endmodule

// File: include/rtc_consts.vh
// Purpose: shared constants of the rtc control and status block
// Assumes: included by bare name from the control and timebase core files
// Notes:   definitions only
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH
// register addresses on the serial link
`define A_SEC 4'h0
`define A_ADJ 4'h7
`define A_CR1 4'he
`define A_CR2 4'hf
// control_one fields
`define B_WK_EN 7
`define B_DY_EN 6
`define B_H24 5
`define B_SPB 4
`define B_TEST 3
// control_status_two fields
`define B_THRESH 7
`define B_LOWSUP 6
`define B_OSCRUN 5
`define B_PWRUP 4
`define B_SPA 3
`define B_PERFLG 2
`define B_WKFLG 1
`define B_DYFLG 0
// periodic select codes
`define PS_OFF 3'h0
`define PS_LOW 3'h1
`define PS_P2 3'h2
`define PS_P1 3'h3
`define PS_L1S 3'h4
`define PS_L1M 3'h5
`define PS_L1H 3'h6
`define PS_L1MO 3'h7
// timing
`define MCLK_MHZ 25
`define T_SECINC_NS 92000
`define T_ALARM_NS 31000
`define DIV_W 15
`define CORR_S20 6'h14
`define CORR_S60 6'h3c
`endif

// File: core/sio_link.v
// Purpose: three-wire serial register port, msb first
// Assumes: byte 0 = {addr[3:0], read, 3'b000}; data bytes follow
// Notes:   address auto-increments per data byte inside one frame
module sio_link (
  input  wire       mclk,     // system clock
  input  wire       srst,     // sync reset, high
  input  wire       ce_pin,   // chip enable pin
  input  wire       sclk_pin, // serial clock pin
  input  wire       sio_in,   // data pin, input side
  output reg        sio_out,  // data pin, output side
  output wire       sio_oe_n, // data pin enable, low drives
  output reg        wr_stb,   // one-cycle write strobe
  output reg  [3:0] addr_r,   // current register address
  output reg  [7:0] wdata,    // write data
  output reg        rd_req,   // one-cycle read request
  input  wire [7:0] rdata     // read data for addr_r
);
  reg [2:0] ce_s, ck_s, io_s;
  reg [2:0] bit_r;
  reg [6:0] sh_r;
  reg [7:0] tx_r;
  reg       cmd_done, rd_r;
  wire      ck_rise = ck_s[1] & ~ck_s[2];
  wire      ck_fall = ~ck_s[1] & ck_s[2];
  wire [7:0] byte_in = {sh_r, io_s[1]};

  // pins cross two flops; the third only feeds edge finding
  always @(posedge mclk) begin
    ce_s <= {ce_s[1:0], ce_pin};
    ck_s <= {ck_s[1:0], sclk_pin};
    io_s <= {io_s[1:0], sio_in};
  end

  assign sio_oe_n = ~(ce_s[1] & cmd_done & rd_r);

  // frame decode and shifting
  always @(posedge mclk) begin
    wr_stb <= 1'b0;
    rd_req <= 1'b0;
    if (srst | ~ce_s[1]) begin
      bit_r    <= 3'h0;
      cmd_done <= 1'b0;
      rd_r     <= 1'b0;
      sio_out  <= 1'b0;
      if (srst) begin
        addr_r <= 4'h0;
        wdata  <= 8'h00;
        sh_r   <= 7'h00;
        tx_r   <= 8'h00;
      end
    end else begin
      if (wr_stb)
        addr_r <= addr_r + 4'h1;
      if (rd_req)
        tx_r <= rdata;
      if (ck_rise) begin
        sh_r  <= byte_in[6:0];
        bit_r <= bit_r + 3'h1;
        if (bit_r == 3'h7) begin
          if (~cmd_done) begin
            cmd_done <= 1'b1;
            addr_r   <= byte_in[7:4];
            rd_r     <= byte_in[3];
            rd_req   <= byte_in[3];
          end else if (rd_r) begin
            addr_r <= addr_r + 4'h1;
            rd_req <= 1'b1;
          end else begin
            wdata  <= byte_in;
            wr_stb <= 1'b1;
          end
        end
      end
      // read data changes on the falling edge
      if (ck_fall & cmd_done & rd_r) begin
        sio_out <= tx_r[7];
        tx_r    <= {tx_r[6:0], 1'b0};
      end
    end
  end
endmodule

// File: core/sec_timebase.v
// Purpose: sub-second divider from the 32.768 kHz oscillator
// Assumes: oscillator pin is asynchronous to mclk
// Notes:   correction trims or stretches one second per period
`include "rtc_consts.vh"
module sec_timebase (
  input  wire                mclk,    // system clock
  input  wire                srst,    // sync reset, high
  input  wire                osc_pin, // 32.768 kHz oscillator
  input  wire                clr,     // restart divider
  input  wire [7:0]          adj,     // correction register
  output reg  [`DIV_W-1:0]   div_r,   // divider phase
  output reg                 tick     // one-cycle second tick
);
  reg [2:0] os_s;
  reg [5:0] corr_r;
  reg [6:0] stall_r;
  wire      osc_rise = os_s[1] & ~os_s[2];
  wire [5:0] corr_end = adj[7] ? `CORR_S20 : `CORR_S60;
  wire      corr_now = (corr_r == corr_end - 6'h1) & (adj[5:0] != 6'h0);

  always @(posedge mclk)
    os_s <= {os_s[1:0], osc_pin};

  // divider with once per period trim
  always @(posedge mclk) begin
    tick <= 1'b0;
    if (srst | clr) begin
      div_r   <= {`DIV_W{1'b0}};
      stall_r <= 7'h00;
      if (srst)
        corr_r <= 6'h00;
    end else if (osc_rise) begin
      if (stall_r != 7'h00)
        stall_r <= stall_r - 7'h01;
      else if (&div_r) begin
        tick   <= 1'b1;
        corr_r <= corr_now ? 6'h00 : corr_r + 6'h01;
        div_r  <= {`DIV_W{1'b0}};
        if (corr_now & ~adj[6])
          div_r <= {{(`DIV_W-7){1'b0}}, adj[5:0], 1'b0};
        if (corr_now & adj[6])
          stall_r <= {adj[5:0], 1'b0};
      end else
        div_r <= div_r + {{(`DIV_W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// File: sim/rtc_ctrl_status_sva.sv
// Purpose: port assertions for rtc_ctrl_status
// Assumes: async pins settle within a few mclk
// Notes:   bound to every instance of the top
module rtc_ctrl_status_sva (
  input wire logic       mclk,         // clock
  input wire logic       srst,         // sync reset
  input wire logic       ce_pin,       // link enable
  input wire logic       pwr_zero_pin, // supply from 0 V
  input wire logic       vlow135_pin,  // below 1.35 V
  input wire logic [4:0] hour_bin,     // hour counter
  input wire logic [5:0] hour_code,    // host hour code
  input wire logic       hour_24,      // hour format
  input wire logic       test_mode,    // test bit
  input wire logic       supply_threshold_sel, // threshold
  input wire logic       mon_en,       // monitor running
  input wire logic [7:0] adj_out,      // correction
  input wire logic       irq_out,      // irq level
  input wire logic       irq_oe_n,     // irq enable
  input wire logic       ext_wr_stb,   // outside write
  input wire logic [3:0] ext_addr      // outside address
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // host hour code; pm hours gain 20 on top of the 12-hour value
  function automatic logic [5:0] hc(input int h, input int f);
    int v;
    v = f ? h : (h == 0 ? 12 : (h > 12 ? h - 12 : h));
    v = v / 10 * 16 + v % 10 + ((f == 0 && h > 11) ? 32 : 0);
    return 6'(v);
  endfunction
  // code follows the counter one cycle late, so wait for both stable
  hour_24_a:
    assert property (!$past(srst) && hour_24 && $stable(hour_24) &&
      $stable(hour_bin) |-> hour_code == hc(hour_bin, 1))
    else $error("hour code wrong in 24-hour mode");
  hour_12_a:
    assert property (!$past(srst) && !hour_24 && $stable(hour_24) &&
      $stable(hour_bin) |-> hour_code == hc(hour_bin, 0))
    else $error("hour code wrong in 12-hour mode");
  pwrup_clear_a:
    assert property ($rose(pwr_zero_pin) |-> ##[1:8] (!hour_24 &&
      !test_mode && !supply_threshold_sel && adj_out == 8'h00))
    else $error("control bits not cleared on power-up");
  pwrup_irq_a:
    assert property ($rose(pwr_zero_pin) |-> ##[1:8] irq_oe_n)
    else $error("irq still driven after power-up");
  vlow_set_a:
    assert property ($rose(vlow135_pin) && supply_threshold_sel
      |-> ##[1:6] !mon_en)
    else $error("low supply not flagged");
  // no frame and no power-up means nothing may restart monitoring
  vlow_hold_a:
    assert property ((!mon_en && !ce_pin && !pwr_zero_pin)[*8]
      |=> !mon_en)
    else $error("low supply flag dropped by itself");
  thresh_sel_a:
    assert property ((mon_en && supply_threshold_sel &&
      !vlow135_pin)[*4] |=> mon_en)
    else $error("wrong threshold watched");
  irq_pin_a:
    assert property (irq_out == 1'b0)
    else $error("irq pin driven high");
  cover property ($fell(irq_oe_n));
  cover property ($fell(mon_en));
  cover property (ext_wr_stb && ext_addr == 4'h0);
endmodule

bind rtc_ctrl_status rtc_ctrl_status_sva rtc_ctrl_status_sva_inst (
  .mclk(mclk), .srst(srst), .ce_pin(ce_pin),
  .pwr_zero_pin(pwr_zero_pin), .vlow135_pin(vlow135_pin),
  .hour_bin(hour_bin), .hour_code(hour_code), .hour_24(hour_24),
  .test_mode(test_mode), .supply_threshold_sel(supply_threshold_sel),
  .mon_en(mon_en), .adj_out(adj_out), .irq_out(irq_out),
  .irq_oe_n(irq_oe_n), .ext_wr_stb(ext_wr_stb), .ext_addr(ext_addr));

// File: sim/host_link.sv
// Purpose: host side of the three-wire register link
// Assumes: link clock idles low, bits taken on its rising edge
// Notes:   released data line wanders so stale bits never pass
module host_link (
  input  wire logic sio_line, // resolved data line
  output logic      ce_pin,   // frame enable
  output logic      sclk_pin, // link clock
  output logic      sio_drv   // host data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ce_pin = 1'b0;
    sclk_pin = 1'b0;
    sio_drv = 1'b0;
  end
  // one byte msb first, data moved only while the clock is low
  task automatic xfer(input logic [7:0] tx, input logic rx_en,
                      output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sio_drv = rx_en ? ~sio_drv : tx[i];
      #160 sclk_pin = 1'b1;
      rx[i] = sio_line;
      #160 sclk_pin = 1'b0;
    end
  endtask
  // command byte then one data byte, then a quiet gap
  task automatic access(input logic [3:0] a, input logic rd,
                        input logic [7:0] d, output logic [7:0] q);
    logic [7:0] nop;
    if (a == 4'he) d[3] = 1'b0;
    ce_pin = 1'b1;
    #200 xfer({a, rd, 3'b000}, 1'b0, nop);
    xfer(d, rd, q);
    #320 ce_pin = 1'b0; // whole periods keep pin moves on negedges
    #400;
  endtask
endmodule

// File: sim/test_rtc_control_status_regs.sv
// Purpose: self-checking bench for the rtc control block
// Assumes: host_link drives the serial pins
// Notes:   a second is too long to run, so tick paths are left out
module test_rtc_control_status_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       osc_pin = 1'b0;
  logic       pwr_zero_pin = 1'b0;
  logic       vlow21_pin = 1'b0;
  logic       vlow135_pin = 1'b0;
  logic       osc_halt_pin = 1'b0;
  logic       alarm_w_match = 1'b0;
  logic       alarm_d_match = 1'b0;
  logic [4:0] hour_bin = 5'h00;
  logic       ce_pin, sclk_pin, sio_drv, sio_out, sio_oe_n, sio_line;
  logic       irq_oe_n, hour_24, supply_threshold_sel, mon_en;
  logic [5:0] hour_code;
  logic [7:0] q;
  int         fails = 0;
  int         total_checks = 0;
  // clocks; the crystal runs free with its own phase
  always #20 mclk = ~mclk;
  always #15259 osc_pin = ~osc_pin;
  assign sio_line = sio_oe_n ? sio_drv : sio_out;
  rtc_ctrl_status rtc_ctrl_status_inst (
    .mclk(mclk), .srst(srst), .ce_pin(ce_pin), .sclk_pin(sclk_pin),
    .sio_in(sio_line), .sio_out(sio_out), .sio_oe_n(sio_oe_n),
    .osc_pin(osc_pin), .pwr_zero_pin(pwr_zero_pin),
    .vlow21_pin(vlow21_pin), .vlow135_pin(vlow135_pin),
    .osc_halt_pin(osc_halt_pin), .alarm_w_match(alarm_w_match),
    .alarm_d_match(alarm_d_match), .sec_carry(1'b0), .min_carry(1'b0),
    .hour_carry(1'b0), .month_carry(1'b0), .hour_bin(hour_bin),
    .hour_code(hour_code), .ext_wr_stb(), .ext_addr(), .ext_wdata(),
    .ext_rdata(8'ha5), .sec_inc(), .irq_out(), .irq_oe_n(irq_oe_n),
    .hour_24(hour_24), .test_mode(),
    .supply_threshold_sel(supply_threshold_sel), .mon_en(mon_en),
    .adj_out());
  host_link host_link_inst (.sio_line(sio_line), .ce_pin(ce_pin),
    .sclk_pin(sclk_pin), .sio_drv(sio_drv));
  // compare and count one result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_link_inst.access(a, 1'b0, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    host_link_inst.access(a, 1'b1, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  function automatic logic [5:0] hc(input int h, input int f);
    int v;
    v = f ? h : (h == 0 ? 12 : (h > 12 ? h - 12 : h));
    v = v / 10 * 16 + v % 10 + ((f == 0 && h > 11) ? 32 : 0);
    return 6'(v);
  endfunction
  // power-up flag blocks control writes until a 0 is written
  task automatic t_power;
    rd(4'hf, 8'h10);
    wr(4'he, 8'hf7);
    rd(4'he, 8'h00);
    chk({7'h00, irq_oe_n}, 8'h01);
    wr(4'hf, 8'h10);
    rd(4'hf, 8'h10);
    wr(4'hf, 8'h00);
    rd(4'hf, 8'h00);
    rd(4'h2, 8'ha5);
  endtask
  // spare bits, oscillator flag, then a new power-up wipes them
  task automatic t_spare;
    wr(4'he, 8'h31);
    rd(4'he, 8'h31);
    chk({7'h00, irq_oe_n}, 8'h00);
    wr(4'hf, 8'ha8);
    rd(4'hf, 8'hac);
    cyc(1);
    osc_halt_pin = 1'b1;
    cyc(6);
    osc_halt_pin = 1'b0;
    rd(4'hf, 8'h8c);
    cyc(1);
    pwr_zero_pin = 1'b1;
    cyc(6);
    pwr_zero_pin = 1'b0;
    rd(4'he, 8'h00);
    rd(4'hf, 8'h10);
    chk({7'h00, irq_oe_n}, 8'h01);
    wr(4'hf, 8'h00);
  endtask
  // every hour in both formats, format chosen first
  task automatic t_hour;
    for (int f = 0; f < 2; f++) begin
      wr(4'he, {2'b00, f[0], 5'h00});
      chk({7'h00, hour_24}, {7'h00, f[0]});
      for (int h = 0; h < 24; h++) begin
        cyc(1);
        hour_bin = h[4:0];
        cyc(3);
        chk({2'b00, hour_code}, {2'b00, hc(h, f)});
      end
    end
  endtask
  // fixed low, periodic flag, divider restart in pulse mode
  task automatic t_irq;
    wr(4'he, 8'h01);
    chk({7'h00, irq_oe_n}, 8'h00);
    rd(4'hf, 8'h04);
    wr(4'he, 8'h03);
    wr(4'h0, 8'h00);
    chk({7'h00, irq_oe_n}, 8'h00);
    wr(4'he, 8'h04);
    rd(4'hf, 8'h00);
    wr(4'he, 8'h00);
    chk({7'h00, irq_oe_n}, 8'h01);
  endtask
  // threshold choice, latch, write 1 ignored, write 0 restarts
  task automatic t_supply;
    wr(4'hf, 8'h80);
    chk({7'h00, supply_threshold_sel}, 8'h01);
    cyc(1);
    vlow21_pin = 1'b1;
    cyc(8);
    chk({7'h00, mon_en}, 8'h01);
    vlow135_pin = 1'b1;
    cyc(8);
    chk({7'h00, mon_en}, 8'h00);
    vlow135_pin = 1'b0;
    vlow21_pin = 1'b0;
    wr(4'hf, 8'hc0);
    rd(4'hf, 8'hc0);
    wr(4'hf, 8'h00);
    rd(4'hf, 8'h00);
  endtask
  // daily alarm lands 775 cycles after match; weekly is disabled
  task automatic t_alarm;
    wr(4'he, 8'h40);
    cyc(1);
    alarm_w_match = 1'b1;
    alarm_d_match = 1'b1;
    cyc(1);
    alarm_w_match = 1'b0;
    alarm_d_match = 1'b0;
    cyc(765);
    chk({7'h00, irq_oe_n}, 8'h01);
    cyc(25);
    chk({7'h00, irq_oe_n}, 8'h00);
    rd(4'hf, 8'h01);
    wr(4'hf, 8'h00);
    chk({7'h00, irq_oe_n}, 8'h01);
  endtask
  task automatic summarize;
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    cyc(20);
    srst = 1'b0;
    cyc(4);
    t_power();
    t_spare();
    t_hour();
    t_irq();
    t_supply();
    t_alarm();
    summarize();
  end
  // hang guard, about twice the expected run
  initial begin
    repeat (12000) @(posedge mclk);
    fails++;
    summarize();
  end
endmodule
